// file: verilog/fbg_defines.vh
`ifndef FBG_DEFINES_VH
`define FBG_DEFINES_VH
// Register byte offsets
`define FBG_REG_CONFIG 8'h00
`define FBG_REG_SOURCE 8'h04
`define FBG_REG_STATUS 8'h08
`define FBG_REG_LINK 8'h0C
`define FBG_REG_PD_BASE 8'h40
// Config fields: [2:0] write rights, [7:4] process words, [10:8] param words, [21:16] fail time
`define FBG_CFG_RIGHTS_LSB 0
`define FBG_CFG_PWC_LSB 4
`define FBG_CFG_KWC_LSB 8
`define FBG_CFG_FAIL_LSB 16
`define FBG_CFG_RESET 32'h00010421
// Source fields: [7:0] control word source, [15:8] setpoint source
`define FBG_SRC_RESET 32'h00003513
// Write-rights values
`define FBG_RIGHTS_PANEL 3'h1
`define FBG_RIGHTS_TECH 3'h3
`define FBG_RIGHTS_BUS 3'h4
// Source selection values
`define FBG_SRC_CTRL_BUS 8'h34
`define FBG_SRC_SETP_BUS 8'h35
// Setpoint scaling: 4000H is full speed
`define FBG_SETP_FULL 16'h4000
// Control word fields
`define FBG_CW_INVERT_BIT 5
`define FBG_CW_REMOTE_BIT 10
// Timing
`define FBG_CLK_MHZ 250
`define FBG_FAIL_UNIT_MS 1500
`define FBG_MAX_FAIL_S 32
`endif

// file: verilog/fbg_pd_ram.v
`timescale 1ns/1ps
// ==========================================
// Dual-port process data store, registered read
module fbg_pd_ram #(
  parameter AW = 4,
  parameter DW = 16
) (
  input wire aclk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: verilog/fbg_gate.v
`timescale 1ns/1ps
`include "fbg_defines.vh"
// Behaviour
// - write rights select panel, tech board, bus
// - bus parameter writes refused without bus rights
// - word counts map to layout types one-five
// - announced master type overrides, settings kept
// - master watchdog value enables response monitoring
// - watchdog expiry freezes process data writes
// - zero control word dropped, alarm raised
// - alarm after watchdog plus fail time times 1.5s
// - host supervision follows fail time setting
// - tech board present disables host bus supervision
// - setpoint 4000H means full speed
// - sources 52 and 53 take bus words
// - fail time zero or above 32 off, else 1.5s units
// - control word bit five inverted to drive
module fbg_gate #(
  parameter WD_UNIT_CYCLES = 2500,
  parameter FAIL_UNIT_CYCLES = `FBG_CLK_MHZ * `FBG_FAIL_UNIT_MS * 1000,
  parameter PD_WORDS = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire link_setup,
  input wire [15:0] link_watchdog,
  input wire link_type_valid,
  input wire [2:0] link_type,
  input wire tel_valid,
  input wire tel_last,
  input wire [15:0] tel_word,
  input wire tel_param_write,
  input wire tech_board_present,
  output reg param_write_accept,
  output reg param_write_reject,
  output reg [2:0] telegram_layout_type,
  output reg config_error,
  output reg bus_alarm,
  output reg wd_expired,
  output reg host_supervise,
  output reg [15:0] drive_control_word,
  output reg [15:0] drive_setpoint,
  output reg [7:0] drive_setpoint_pct
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RECV = 2'h1;
  localparam ST_COPY = 2'h2;
  localparam ST_DROP = 2'h3;

  // ==========================================
  // Helpers
  function [2:0] fbg_layout;
    input [3:0] pwc;
    input [2:0] kwc;
    begin
      case ({pwc, kwc})
        {4'h2, 3'h4}: fbg_layout = 3'h1;
        {4'h6, 3'h4}: fbg_layout = 3'h2;
        {4'h2, 3'h0}: fbg_layout = 3'h3;
        {4'h6, 3'h0}: fbg_layout = 3'h4;
        {4'hA, 3'h4}: fbg_layout = 3'h5;
        default: fbg_layout = 3'h0;
      endcase
    end
  endfunction

  function [3:0] fbg_words;
    input [2:0] lt;
    begin
      case (lt)
        3'h1, 3'h3: fbg_words = 4'h2;
        3'h2, 3'h4: fbg_words = 4'h6;
        3'h5: fbg_words = 4'hA;
        default: fbg_words = 4'h0;
      endcase
    end
  endfunction

  // ==========================================
  // Register bus
  reg [31:0] cfg;
  reg [31:0] src;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  reg rd_pend;
  reg rd_ram;
  reg [31:0] rd_val;
  reg [15:0] wd_value;
  reg wd_active;
  wire [15:0] ram_rdata;
  wire [7:0] ar_off = s_axi_araddr - `FBG_REG_PD_BASE;
  wire ar_is_pd = (s_axi_araddr >= `FBG_REG_PD_BASE) && (ar_off[7:2] < PD_WORDS);

  wire [2:0] rights = cfg[`FBG_CFG_RIGHTS_LSB +: 3];
  wire [3:0] pwc = cfg[`FBG_CFG_PWC_LSB +: 4];
  wire [2:0] kwc = cfg[`FBG_CFG_KWC_LSB +: 3];
  wire [5:0] fail_time = cfg[`FBG_CFG_FAIL_LSB +: 6];
  wire [2:0] cfg_layout = fbg_layout(pwc, kwc);

  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      cfg <= `FBG_CFG_RESET;
      src <= `FBG_SRC_RESET;
      rd_pend <= 1'b0;
      rd_ram <= 1'b0;
      rd_val <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr == `FBG_REG_CONFIG) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (w_strb[i]) begin
              cfg[i*8 +: 8] <= w_data[i*8 +: 8];
            end
          end
        end else if (aw_addr == `FBG_REG_SOURCE) begin
          for (i = 0; i < 2; i = i + 1) begin
            if (w_strb[i]) begin
              src[i*8 +: 8] <= w_data[i*8 +: 8];
            end
          end
        end else if (aw_addr != `FBG_REG_STATUS && aw_addr != `FBG_REG_LINK) begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !rd_pend && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_pend <= 1'b1;
        rd_ram <= ar_is_pd;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `FBG_REG_CONFIG: rd_val <= cfg;
          `FBG_REG_SOURCE: rd_val <= {16'h0000, src[15:0]};
          `FBG_REG_STATUS: rd_val <= {24'h000000, wd_active, wd_expired, config_error,
                                      bus_alarm, host_supervise, telegram_layout_type};
          `FBG_REG_LINK: rd_val <= {16'h0000, wd_value};
          default: begin
            rd_val <= 32'h00000000;
            if (!ar_is_pd) begin
              s_axi_rresp <= 2'h2;
            end
          end
        endcase
      end
      // One extra cycle so the RAM's registered output is ready
      if (rd_pend && !rd_ram) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
      end else if (rd_pend && rd_ram) begin
        rd_ram <= 1'b0;
        rd_val <= {16'h0000, ram_rdata};
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Link setup: watchdog and announced type
  reg [2:0] master_layout;
  reg [31:0] wd_cnt;
  reg [31:0] fail_cnt;
  reg [5:0] fail_units;
  reg tel_good;
  wire wd_limit_hit = (wd_cnt + 32'h1) >= ({16'h0000, wd_value} * WD_UNIT_CYCLES);

  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_value <= 16'h0000;
      wd_active <= 1'b0;
      master_layout <= 3'h0;
      telegram_layout_type <= 3'h0;
      config_error <= 1'b0;
      host_supervise <= 1'b0;
      param_write_accept <= 1'b0;
      param_write_reject <= 1'b0;
    end else begin
      if (link_setup) begin
        wd_value <= link_watchdog;
        wd_active <= (link_watchdog != 16'h0000);
      end
      if (link_type_valid && fbg_words(link_type) != 4'h0) begin
        master_layout <= link_type;
      end
      // Master's announced type wins; cfg fields stay untouched
      telegram_layout_type <= (master_layout != 3'h0) ? master_layout : cfg_layout;
      config_error <= (cfg_layout == 3'h0) && (master_layout == 3'h0);
      host_supervise <= (fail_time != 6'h00) && (fail_time <= `FBG_MAX_FAIL_S) && wd_active
                        && !tech_board_present;
      param_write_accept <= tel_param_write && (rights == `FBG_RIGHTS_BUS);
      param_write_reject <= tel_param_write && (rights != `FBG_RIGHTS_BUS);
    end
  end

  // ==========================================
  // Response watchdog and failure alarm
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt <= 32'h00000000;
      wd_expired <= 1'b0;
      fail_cnt <= 32'h00000000;
      fail_units <= 6'h00;
    end else if (!wd_active || tel_good || link_setup) begin
      wd_cnt <= 32'h00000000;
      wd_expired <= 1'b0;
      fail_cnt <= 32'h00000000;
      fail_units <= 6'h00;
    end else if (!wd_expired) begin
      wd_cnt <= wd_cnt + 32'h1;
      if (wd_limit_hit) begin
        wd_expired <= 1'b1;
      end
    end else if (fail_units < fail_time) begin
      // Extra 1.5 s per fail-time unit after the watchdog lapses
      if (fail_cnt + 32'h1 >= FAIL_UNIT_CYCLES) begin
        fail_cnt <= 32'h00000000;
        fail_units <= fail_units + 6'h1;
      end else begin
        fail_cnt <= fail_cnt + 32'h1;
      end
    end
  end

  wire fail_alarm = wd_expired && (fail_units >= fail_time) && host_supervise;

  // ==========================================
  // Telegram reception
  reg [1:0] state;
  reg [3:0] widx;
  reg [15:0] first_word;
  reg [15:0] second_word;
  wire [22:0] sp_prod = {7'h00, second_word} * 23'h000064;
  reg zero_alarm;
  wire ram_we = tel_valid && (state != ST_DROP) && !wd_expired && (widx < PD_WORDS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      widx <= 4'h0;
      first_word <= 16'h0000;
      second_word <= 16'h0000;
      tel_good <= 1'b0;
      zero_alarm <= 1'b0;
      bus_alarm <= 1'b0;
      drive_control_word <= 16'h0000;
      drive_setpoint <= 16'h0000;
      drive_setpoint_pct <= 8'h00;
    end else begin
      tel_good <= 1'b0;
      bus_alarm <= zero_alarm || fail_alarm;
      case (state)
        ST_IDLE: begin
          if (tel_valid) begin
            widx <= 4'h1;
            first_word <= tel_word;
            if (tel_word == 16'h0000) begin
              state <= tel_last ? ST_IDLE : ST_DROP;
              zero_alarm <= 1'b1;
            end else begin
              state <= tel_last ? ST_COPY : ST_RECV;
              zero_alarm <= 1'b0;
            end
          end
        end
        ST_RECV: begin
          if (tel_valid) begin
            widx <= widx + 4'h1;
            second_word <= (widx == 4'h1) ? tel_word : second_word;
            if (tel_last) begin
              state <= ST_COPY;
            end
          end
        end
        ST_COPY: begin
          tel_good <= 1'b1;
          state <= ST_IDLE;
          if (!wd_expired && first_word[`FBG_CW_REMOTE_BIT]) begin
            if (src[7:0] == `FBG_SRC_CTRL_BUS) begin
              drive_control_word <= first_word ^ (16'h1 << `FBG_CW_INVERT_BIT);
            end
            if (src[15:8] == `FBG_SRC_SETP_BUS) begin
              drive_setpoint <= second_word;
              drive_setpoint_pct <= (second_word >= `FBG_SETP_FULL) ? 8'h64 : sp_prod[21:14];
            end
          end
        end
        ST_DROP: begin
          if (tel_valid && tel_last) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Zero control words never reach RAM; later words of that set are dropped too
  fbg_pd_ram #(.AW(4), .DW(16)) u_ram (
    .aclk(aclk),
    .we(ram_we && !(state == ST_IDLE && tel_word == 16'h0000)),
    .waddr((state == ST_IDLE) ? 4'h0 : widx),
    .wdata(tel_word),
    .raddr(ar_off[5:2]),
    .rdata(ram_rdata)
  );
endmodule

// file: sim/fbg_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port-level checks on the gate
module fbg_checker (
  input wire aclk,
  input wire aresetn,
  input wire tel_param_write,
  input wire param_write_accept,
  input wire param_write_reject,
  input wire link_type_valid,
  input wire [2:0] link_type,
  input wire [2:0] telegram_layout_type,
  input wire config_error,
  input wire link_setup,
  input wire [15:0] link_watchdog,
  input wire wd_expired,
  input wire tech_board_present,
  input wire host_supervise
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_req;
    tel_param_write;
  endsequence
  sequence s_answer;
    param_write_accept ^ param_write_reject;
  endsequence
  sequence s_off;
    link_setup && link_watchdog == 16'h0000;
  endsequence
  AST_PW_ONE: assert property (s_req |=> s_answer)
    else $error("parameter request without single answer");
  AST_PW_CAUSE: assert property ((param_write_accept || param_write_reject) |-> $past(tel_param_write))
    else $error("parameter answer without request");
  AST_PW_EXCL: assert property (!(param_write_accept && param_write_reject))
    else $error("accept and reject together");
  AST_TYPE_HOST: assert property (link_type_valid && link_type == 3'h5 |-> ##[1:2] telegram_layout_type == 3'h5)
    else $error("announced layout not taken");
  AST_CFG_NONE: assert property (config_error |-> telegram_layout_type == 3'h0)
    else $error("layout selected despite bad counts");
  AST_TYPE_RANGE: assert property (telegram_layout_type <= 3'h5)
    else $error("layout type out of range");
  AST_WD_OFF: assert property (s_off |-> ##2 !wd_expired)
    else $error("watchdog active while disabled");
  AST_TECH: assert property (tech_board_present [*2] |-> !host_supervise)
    else $error("host supervision with tech board");
endmodule

// file: sim/fbg_master_model.sv
`timescale 1ns/1ps
// ==========================================
// Fieldbus master side of the gate
module fbg_master_model (
  input wire aclk,
  output reg link_setup,
  output reg [15:0] link_watchdog,
  output reg link_type_valid,
  output reg [2:0] link_type,
  output reg tel_valid,
  output reg tel_last,
  output reg [15:0] tel_word,
  output reg tel_param_write
);
  initial begin
    {link_setup, link_type_valid, tel_valid, tel_last, tel_param_write} = 5'h00;
    {link_watchdog, tel_word, link_type} = 35'h0;
  end
  // Stale values are inverted so late sampling shows up
  task setup(input [15:0] wd);
    begin
      @(posedge aclk);
      link_setup <= 1'b1;
      link_watchdog <= wd;
      @(posedge aclk);
      link_setup <= 1'b0;
      link_watchdog <= ~wd;
    end
  endtask
  // Only called when the master can announce its type
  task announce(input [2:0] t);
    begin
      @(posedge aclk);
      link_type_valid <= 1'b1;
      link_type <= t;
      @(posedge aclk);
      link_type_valid <= 1'b0;
      link_type <= ~t;
    end
  endtask
  task param_wr;
    begin
      @(posedge aclk);
      tel_param_write <= 1'b1;
      @(posedge aclk);
      tel_param_write <= 1'b0;
    end
  endtask
  // Control word always goes first
  task send(input [15:0] cw, input [15:0] sp);
    begin
      @(posedge aclk);
      tel_valid <= 1'b1;
      tel_word <= cw;
      @(posedge aclk);
      tel_word <= sp;
      tel_last <= 1'b1;
      @(posedge aclk);
      tel_valid <= 1'b0;
      tel_last <= 1'b0;
      tel_word <= ~sp;
    end
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Gate testbench
module tb_top;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tech_board_present;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, d;
  reg [3:0] s_axi_wstrb, strb;
  reg [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire link_setup, link_type_valid, tel_valid, tel_last, tel_param_write;
  wire [15:0] link_watchdog, tel_word, drive_control_word, drive_setpoint;
  wire [2:0] link_type, telegram_layout_type;
  wire param_write_accept, param_write_reject, config_error, bus_alarm, wd_expired, host_supervise;
  wire [7:0] drive_setpoint_pct;
  integer n_mismatch, n_tests;
  // Short units keep the watchdog and alarm spans to tens of cycles
  fbg_gate #(.WD_UNIT_CYCLES(50), .FAIL_UNIT_CYCLES(20), .PD_WORDS(10)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .link_setup(link_setup), .link_watchdog(link_watchdog), .link_type_valid(link_type_valid),
    .link_type(link_type), .tel_valid(tel_valid), .tel_last(tel_last), .tel_word(tel_word),
    .tel_param_write(tel_param_write), .tech_board_present(tech_board_present),
    .param_write_accept(param_write_accept), .param_write_reject(param_write_reject),
    .telegram_layout_type(telegram_layout_type), .config_error(config_error), .bus_alarm(bus_alarm),
    .wd_expired(wd_expired), .host_supervise(host_supervise), .drive_control_word(drive_control_word),
    .drive_setpoint(drive_setpoint), .drive_setpoint_pct(drive_setpoint_pct));
  fbg_master_model i_mst (
    .aclk(aclk), .link_setup(link_setup), .link_watchdog(link_watchdog), .link_type_valid(link_type_valid),
    .link_type(link_type), .tel_valid(tel_valid), .tel_last(tel_last), .tel_word(tel_word),
    .tel_param_write(tel_param_write));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task finish_test;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    reg done;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task rd(input [7:0] a);
    reg done;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(d, e);
    end
  endtask
  task sendw(input [15:0] cw, input [15:0] sp);
    begin
      i_mst.send(cw, sp);
      repeat (6) @(posedge aclk);
    end
  endtask
  task pw(input a);
    reg sa, sr;
    begin
      sa = 1'b0;
      sr = 1'b0;
      i_mst.param_wr;
      repeat (3) begin
        @(posedge aclk);
        sa = sa | param_write_accept;
        sr = sr | param_write_reject;
      end
      chk(sa, a);
      chk(sr, !a);
    end
  endtask
  task t_regs;
    begin
      rc(8'h00, 32'h00010421);
      rc(8'h04, 32'h00003513);
      rd(8'h20);
      chk(r, 2'h2);
      wr(8'h20, 32'h00000000);
      chk(r, 2'h2);
      chk(telegram_layout_type, 3'h1);
    end
  endtask
  task t_layout;
    integer k;
    reg [83:0] tab;
    reg [11:0] e;
    begin
      tab = 84'h241642203604A45340220;
      for (k = 0; k < 7; k = k + 1) begin
        e = tab[k*12 +: 12];
        wr(8'h00, {10'h000, 6'h01, 5'h00, e[6:4], e[11:8], 4'h1});
        repeat (2) @(posedge aclk);
        chk(telegram_layout_type, e[2:0]);
        chk(config_error, e[2:0] == 3'h0);
      end
      wr(8'h00, 32'h00010421);
    end
  endtask
  task t_rights;
    begin
      pw(1'b0);
      wr(8'h00, 32'h00010423);
      pw(1'b0);
      strb = 4'h1;
      wr(8'h00, 32'hFFFFFF24);
      strb = 4'hF;
      rc(8'h00, 32'h00010424);
      pw(1'b1);
      wr(8'h00, 32'h00010421);
    end
  endtask
  task t_host;
    begin
      i_mst.setup(16'hFFFF);
      repeat (2) @(posedge aclk);
      chk(host_supervise, 1'b1);
      tech_board_present <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(host_supervise, 1'b0);
      tech_board_present <= 1'b0;
      wr(8'h00, 32'h00000421);
      repeat (2) @(posedge aclk);
      chk(host_supervise, 1'b0);
      wr(8'h00, 32'h00010421);
    end
  endtask
  task t_pd;
    begin
      sendw(16'h0400, 16'h2000);
      chk(drive_control_word, 16'h0000);
      chk(drive_setpoint, 16'h2000);
      chk(drive_setpoint_pct, 8'h32);
      wr(8'h04, 32'h00003534);
      sendw(16'h0400, 16'h4000);
      chk(drive_control_word, 16'h0420);
      chk(drive_setpoint, 16'h4000);
      chk(drive_setpoint_pct, 8'h64);
      sendw(16'h0000, 16'h1000);
      chk(bus_alarm, 1'b1);
      rc(8'h40, 32'h00000400);
      chk(drive_setpoint, 16'h4000);
    end
  endtask
  task t_wd;
    integer n;
    begin
      i_mst.setup(16'h0001);
      sendw(16'h0400, 16'h3000);
      chk(bus_alarm, 1'b0);
      n = 0;
      while (wd_expired !== 1'b1 && n < 200) begin
        @(posedge aclk);
        n = n + 1;
      end
      chk(n > 37 && n < 49, 1'b1);
      repeat (10) @(posedge aclk);
      chk(bus_alarm, 1'b0);
      repeat (15) @(posedge aclk);
      chk(bus_alarm, 1'b1);
      sendw(16'h0401, 16'h1111);
      chk(drive_control_word, 16'h0420);
      rc(8'h40, 32'h00000400);
      i_mst.setup(16'h0000);
      repeat (3) @(posedge aclk);
      chk(wd_expired, 1'b0);
    end
  endtask
  task t_type;
    begin
      i_mst.announce(3'h5);
      repeat (3) @(posedge aclk);
      chk(telegram_layout_type, 3'h5);
      rc(8'h00, 32'h00010421);
    end
  endtask
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tech_board_present} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {strb, s_axi_wstrb} = 8'hFF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_layout;
    t_rights;
    t_host;
    t_pd;
    t_wd;
    t_type;
    finish_test;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
endmodule
bind fbg_gate fbg_checker i_chk (.aclk(aclk), .aresetn(aresetn), .tel_param_write(tel_param_write),
  .param_write_accept(param_write_accept), .param_write_reject(param_write_reject),
  .link_type_valid(link_type_valid), .link_type(link_type), .telegram_layout_type(telegram_layout_type),
  .config_error(config_error), .link_setup(link_setup), .link_watchdog(link_watchdog),
  .wd_expired(wd_expired), .tech_board_present(tech_board_present), .host_supervise(host_supervise));
